// ---- hdl/dcd_map.vh ----
// register offsets, reset values and field positions of the two-channel dac
`ifndef DCD_MAP_VH
`define DCD_MAP_VH
`define DCD_ADDR_W        32
`define DCD_ADDR_CODE0    32'h040000a0
`define DCD_ADDR_CODE1    32'h040000a2
`define DCD_ADDR_CTRL     32'h040000a4
`define DCD_CODE_RESET    8'h00
`define DCD_CTRL_RESET    8'h1f
`define DCD_CTRL_RSVD     5'h1f
`define DCD_BIT_OE1       7
`define DCD_BIT_OE0       6
`define DCD_BIT_CEN       5
`define DCD_CONV_TIME_NS  10000
`define DCD_CLK_PERIOD_NS 100
`define DCD_CONV_CYCLES   (`DCD_CONV_TIME_NS / `DCD_CLK_PERIOD_NS)
`define DCD_CNT_W         7
`define DCD_CNT_ZERO      7'h00
`define DCD_CNT_ONE       7'h01
`define DCD_CONV_LOAD     7'h64
`define DCD_CTRL_EN_RESET 3'h0
`define DCD_OUT_OFF       8'h00
`define DCD_RDATA_IDLE    8'h00
`define DCD_PIN_RELEASED  1'b1
`define DCD_ACT_RESET     1'b0
`endif

// ---- hdl/dcd_enable_logic.v ----
// combinational per-channel conversion enable derived from control bits
`timescale 1ns/1ps
`default_nettype none
module dcd_enable_logic (
   input  wire       oe0,
   input  wire       oe1,
   input  wire       cen,
   output wire       conv_en0,
   output wire       conv_en1
);
   // common enable couples channels only when some output enable is set
   assign conv_en0 = oe0 | (cen & oe1); // RULE5 RULE6 RULE7 RULE8 RULE15
   assign conv_en1 = oe1 | (cen & oe0); // RULE4 RULE6 RULE7 RULE8 RULE15
endmodule // dcd_enable_logic
`default_nettype wire

// ---- hdl/dcd_channel.v ----
// one conversion channel: settles a code to the output after the conv time
`timescale 1ns/1ps
`default_nettype none
`include "dcd_map.vh"
module dcd_channel (
   input  wire       sys_clk,
   input  wire       nrst,
   input  wire       conv_en,
   input  wire       code_wr,
   input  wire [7:0] code,
   output reg  [7:0] level_ff,
   output reg        settled_ff
);
   reg [`DCD_CNT_W-1:0] cnt_ff;
   wire restart;
   assign restart = code_wr |
                    (conv_en & ~settled_ff & (cnt_ff == `DCD_CNT_ZERO));
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff     <= `DCD_CNT_ZERO;
         level_ff   <= `DCD_CODE_RESET;
         settled_ff <= 1'b0;
      end else if (!conv_en) begin
         cnt_ff     <= `DCD_CNT_ZERO;
         settled_ff <= 1'b0;
      end else if (restart) begin // RULE9
         // new code restarts conversion; the old result stays until it ends
         cnt_ff <= `DCD_CONV_LOAD;
      end else if (cnt_ff != `DCD_CNT_ZERO) begin
         cnt_ff <= cnt_ff - `DCD_CNT_ONE;
         if (cnt_ff == `DCD_CNT_ONE) begin
            level_ff   <= code; // RULE12
            settled_ff <= 1'b1; // RULE10
         end
      end
   end
endmodule // dcd_channel
`default_nettype wire

// ---- hdl/dcd_dac_ctrl.v ----
// register file and output control of the two-channel 8-bit dac
`timescale 1ns/1ps
`default_nettype none
`include "dcd_map.vh"
// Behaviour
// RULE1: two 8-bit code registers, reset to zero
// RULE2: control register resets to 0x1f
// RULE3: control bits 4..0 read one, ignore writes
// RULE4: bit 7 enables channel 1 output
// RULE5: bit 6 enables channel 0 output
// RULE6: common enable low: channels independent
// RULE7: common enable with any enable: both convert
// RULE8: both output enables low: none convert
// RULE9: enabled channel converts, restarts on write
// RULE10: result held until rewrite or disable
// RULE11: cleared output enable releases analogue pin
// RULE12: output equals code over 256 of reference
// RULE13: standby holds the current analogue output
// RULE14: software clears enables before standby
// RULE15: enables follow control bits next cycle
module dcd_dac_ctrl (
   input  wire                   sys_clk,
   input  wire                   nrst,
   input  wire                   bus_sel,
   input  wire                   bus_wr,
   input  wire [`DCD_ADDR_W-1:0] bus_addr,
   input  wire [7:0]             bus_wdata,
   input  wire                   standby,
   output reg  [7:0]             bus_rdata_ff,
   output reg  [7:0]             analog_out_channel0_ff,
   output reg  [7:0]             analog_out_channel1_ff,
   output reg                    analog_out_channel0_oe_n_ff,
   output reg                    analog_out_channel1_oe_n_ff,
   output reg                    conv_active0_ff,
   output reg                    conv_active1_ff
);
   reg  [7:0] dac_code_channel0_ff;
   reg  [7:0] dac_code_channel1_ff;
   reg  [2:0] ctrl_ff;
   wire       channel1_output_enable;
   wire       channel0_output_enable;
   wire       common_convert_enable;
   wire       wr0;
   wire       wr1;
   wire       wrc;
   wire       en0;
   wire       en1;
   wire [7:0] lvl0;
   wire [7:0] lvl1;
   wire       set0;
   wire       set1;
   wire [7:0] dac_control;
   reg  [7:0] nxt_rdata;
   reg  [7:0] nxt_code0;
   reg  [7:0] nxt_code1;
   reg  [2:0] nxt_ctrl;
   reg  [7:0] nxt_out0;
   reg  [7:0] nxt_out1;
   reg        nxt_oe_n0;
   reg        nxt_oe_n1;
   reg        nxt_act0;
   reg        nxt_act1;
   reg  [7:0] nxt_rdata_out;

   function hit;
      input [`DCD_ADDR_W-1:0] a;
      input [`DCD_ADDR_W-1:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // a write strobe needs select, write and an exact address match
   function wr_strobe;
      input                   sel;
      input                   wr;
      input [`DCD_ADDR_W-1:0] a;
      input [`DCD_ADDR_W-1:0] target;
      begin
         wr_strobe = sel & wr & hit(a, target);
      end
   endfunction

   // a pin shows its level only after the first conversion settles
   function [7:0] drive_level;
      input       oe;
      input       settled;
      input [7:0] level;
      begin
         drive_level = (oe & settled) ? level : `DCD_OUT_OFF;
      end
   endfunction

   assign channel1_output_enable = ctrl_ff[2];
   assign channel0_output_enable = ctrl_ff[1];
   assign common_convert_enable  = ctrl_ff[0];
   assign dac_control = {channel1_output_enable, channel0_output_enable,
                         common_convert_enable, `DCD_CTRL_RSVD}; // RULE3
   assign wr0 = wr_strobe(bus_sel, bus_wr, bus_addr, `DCD_ADDR_CODE0);
   assign wr1 = wr_strobe(bus_sel, bus_wr, bus_addr, `DCD_ADDR_CODE1);
   assign wrc = wr_strobe(bus_sel, bus_wr, bus_addr, `DCD_ADDR_CTRL);

   always @* begin
      nxt_code0 = dac_code_channel0_ff;
      if (wr0) begin
         nxt_code0 = bus_wdata; // RULE9
      end
   end

   always @* begin
      nxt_code1 = dac_code_channel1_ff;
      if (wr1) begin
         nxt_code1 = bus_wdata; // RULE9
      end
   end

   always @* begin
      nxt_ctrl = ctrl_ff;
      if (wrc) begin
         // only the three enable bits store; reserved bits are fixed
         nxt_ctrl = bus_wdata[`DCD_BIT_OE1:`DCD_BIT_CEN]; // RULE3
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dac_code_channel0_ff <= `DCD_CODE_RESET; // RULE1
      end else begin
         dac_code_channel0_ff <= nxt_code0;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dac_code_channel1_ff <= `DCD_CODE_RESET; // RULE1
      end else begin
         dac_code_channel1_ff <= nxt_code1;
      end
   end

   // only the enable bits are kept, so their reset is the top three bits
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= `DCD_CTRL_EN_RESET; // RULE2
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   dcd_enable_logic u_en (
      .oe0      (channel0_output_enable),
      .oe1      (channel1_output_enable),
      .cen      (common_convert_enable),
      .conv_en0 (en0),
      .conv_en1 (en1)
   );

   dcd_channel u_ch0 (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .conv_en    (en0),
      .code_wr    (wr0),
      .code       (dac_code_channel0_ff),
      .level_ff   (lvl0),
      .settled_ff (set0)
   );

   dcd_channel u_ch1 (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .conv_en    (en1),
      .code_wr    (wr1),
      .code       (dac_code_channel1_ff),
      .level_ff   (lvl1),
      .settled_ff (set1)
   );

   always @* begin
      case (bus_addr)
         `DCD_ADDR_CODE0: begin
            nxt_rdata = dac_code_channel0_ff; // RULE1
         end
         `DCD_ADDR_CODE1: begin
            nxt_rdata = dac_code_channel1_ff; // RULE1
         end
         `DCD_ADDR_CTRL: begin
            nxt_rdata = dac_control; // RULE3
         end
         default: begin
            nxt_rdata = `DCD_RDATA_IDLE;
         end
      endcase
   end

   // unselected cycles read zero so a stale word never lingers on the bus
   always @* begin
      nxt_rdata_out = `DCD_RDATA_IDLE;
      if (bus_sel) begin
         nxt_rdata_out = nxt_rdata;
      end
   end

   // standby freezes the pin side as it is; enables are not touched
   always @* begin
      nxt_oe_n0 = analog_out_channel0_oe_n_ff;
      if (!standby) begin // RULE13
         nxt_oe_n0 = ~channel0_output_enable; // RULE11
      end
   end

   always @* begin
      nxt_oe_n1 = analog_out_channel1_oe_n_ff;
      if (!standby) begin // RULE13
         nxt_oe_n1 = ~channel1_output_enable; // RULE11
      end
   end

   always @* begin
      nxt_out0 = analog_out_channel0_ff;
      if (!standby) begin // RULE13
         nxt_out0 = drive_level(channel0_output_enable, set0, lvl0); // RULE10
      end
   end

   always @* begin
      nxt_out1 = analog_out_channel1_ff;
      if (!standby) begin // RULE13
         nxt_out1 = drive_level(channel1_output_enable, set1, lvl1); // RULE10
      end
   end

   always @* begin
      nxt_act0 = conv_active0_ff;
      if (!standby) begin // RULE13
         nxt_act0 = en0; // RULE9
      end
   end

   always @* begin
      nxt_act1 = conv_active1_ff;
      if (!standby) begin // RULE13
         nxt_act1 = en1; // RULE9
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bus_rdata_ff <= `DCD_RDATA_IDLE;
      end else begin
         bus_rdata_ff <= nxt_rdata_out;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         analog_out_channel0_oe_n_ff <= `DCD_PIN_RELEASED;
      end else begin
         analog_out_channel0_oe_n_ff <= nxt_oe_n0;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         analog_out_channel1_oe_n_ff <= `DCD_PIN_RELEASED;
      end else begin
         analog_out_channel1_oe_n_ff <= nxt_oe_n1;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         analog_out_channel0_ff <= `DCD_OUT_OFF;
      end else begin
         analog_out_channel0_ff <= nxt_out0;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         analog_out_channel1_ff <= `DCD_OUT_OFF;
      end else begin
         analog_out_channel1_ff <= nxt_out1;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         conv_active0_ff <= `DCD_ACT_RESET;
      end else begin
         conv_active0_ff <= nxt_act0;
      end
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         conv_active1_ff <= `DCD_ACT_RESET;
      end else begin
         conv_active1_ff <= nxt_act1;
      end
   end
endmodule // dcd_dac_ctrl
`default_nettype wire

// ---- tb/dcd_dac_ctrl_assertions.sv ----
// port assertions for the two-channel dac control
`timescale 1ns/1ps
`default_nettype none
module dcd_chk (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        bus_sel,
   input wire logic        bus_wr,
   input wire logic [31:0] bus_addr,
   input wire logic [7:0]  bus_wdata,
   input wire logic        standby,
   input wire logic [7:0]  bus_rdata_ff,
   input wire logic [7:0]  analog_out_channel0_ff,
   input wire logic [7:0]  analog_out_channel1_ff,
   input wire logic        analog_out_channel0_oe_n_ff,
   input wire logic        analog_out_channel1_oe_n_ff,
   input wire logic        conv_active0_ff,
   input wire logic        conv_active1_ff
);
   wire       hit = bus_addr == 32'h040000a4;
   wire       wc = bus_sel & bus_wr & hit;
   wire [2:0] m = bus_wdata[7:5];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   AST_RSVD: assert property
      (bus_sel && !bus_wr && hit |=> bus_rdata_ff[4:0] == 5'h1f)
      else $error("reserved control bits not one");
   AST_OE1: assert property
      (wc && !m[2] ##0 !standby[*3] |-> analog_out_channel1_oe_n_ff)
      else $error("channel 1 pin still driven");
   AST_OE0: assert property
      (wc && m[1] ##0 !standby[*3] |-> !analog_out_channel0_oe_n_ff)
      else $error("channel 0 pin not driven");
   AST_OFF: assert property
      (wc && m[2:1] == 2'b00 ##0 !standby[*3]
       |-> !conv_active0_ff && !conv_active1_ff)
      else $error("conversion active with both enables clear");
   AST_COM: assert property
      (wc && m == 3'b011 ##0 !standby[*3] |-> conv_active1_ff)
      else $error("common enable did not start channel 1");
   AST_IND: assert property
      (wc && m == 3'b010 ##0 !standby[*3]
       |-> conv_active0_ff && !conv_active1_ff)
      else $error("channels not independent");
   AST_REL: assert property
      (analog_out_channel0_oe_n_ff |-> analog_out_channel0_ff == 8'h00)
      else $error("released channel 0 shows a level");
   AST_REL1: assert property
      (analog_out_channel1_oe_n_ff |-> analog_out_channel1_ff == 8'h00)
      else $error("released channel 1 shows a level");
   AST_HOLD: assert property
      (standby ##1 standby |-> $stable(analog_out_channel0_ff)
       && $stable(analog_out_channel0_oe_n_ff))
      else $error("output moved in standby");
endmodule // dcd_chk
`default_nettype wire

// ---- tb/dcd_dac_ctrl_tb.sv ----
// self-checking bench for the two-channel dac control
`timescale 1ns/1ps
`default_nettype none
`include "dcd_map.vh"
module dcd_dac_ctrl_tb;
   logic        sys_clk, nrst, bus_sel, bus_wr, standby, rd_d;
   logic [31:0] bus_addr;
   logic [7:0]  bus_wdata, rdata, out0, out1, v, w;
   logic        oen0, oen1, act0, act1;
   logic [7:0]  q[$];
   integer      seed = 32'h2714, fails = 0, checked = 0, i;
   dcd_dac_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst), .bus_sel(bus_sel),
      .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .standby(standby), .bus_rdata_ff(rdata),
      .analog_out_channel0_ff(out0), .analog_out_channel1_ff(out1),
      .analog_out_channel0_oe_n_ff(oen0), .analog_out_channel1_oe_n_ff(oen1),
      .conv_active0_ff(act0), .conv_active1_ff(act1));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t exp %h got %h", $time, e, g);
      end
   endtask
   task tally_and_finish;
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task acc(input logic wr, input logic [31:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_sel <= 1'b1;
      bus_wr <= wr;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_sel <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [7:0] e);
      q.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   // outputs are looked at mid-cycle, clear of the edge updates
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   always @(posedge sys_clk) rd_d <= bus_sel & ~bus_wr;
   always @(negedge sys_clk) if (rd_d) chk(q.pop_front(), rdata);
   initial begin
      nrst = 1'b0;
      {bus_sel, bus_wr, standby, bus_addr, bus_wdata} = '0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`DCD_ADDR_CODE0, 8'h00);
      rd(`DCD_ADDR_CTRL, 8'h1f);
      rd(32'h040000a6, 8'h00);
      v = 8'($random(seed)) | 8'h01;
      w = ~v;
      acc(1'b1, `DCD_ADDR_CODE0, v);
      acc(1'b1, `DCD_ADDR_CODE1, w);
      rd(`DCD_ADDR_CODE0, v);
      rd(`DCD_ADDR_CODE1, w);
      for (i = 0; i < 8; i++) begin
         acc(1'b1, `DCD_ADDR_CTRL, {i[2:0], 5'h00});
         rd(`DCD_ADDR_CTRL, {i[2:0], 5'h1f});
         cyc(1);
         chk({7'h0, i[1] | i[0] & i[2]}, {7'h0, act0});
         chk({7'h0, i[2] | i[0] & i[1]}, {7'h0, act1});
         chk({7'h0, ~i[1]}, {7'h0, oen0});
         chk({7'h0, ~i[2]}, {7'h0, oen1});
      end
      acc(1'b1, `DCD_ADDR_CTRL, 8'h00);
      acc(1'b1, `DCD_ADDR_CTRL, 8'h40);
      cyc(50);
      chk(8'h00, out0);
      cyc(60);
      chk(v, out0);
      chk(8'h00, out1);
      acc(1'b1, `DCD_ADDR_CODE0, w);
      cyc(50);
      chk(v, out0);
      cyc(60);
      chk(w, out0);
      @(posedge sys_clk);
      standby <= 1'b1;
      acc(1'b1, `DCD_ADDR_CODE0, v);
      cyc(110);
      chk(w, out0);
      @(posedge sys_clk);
      standby <= 1'b0;
      acc(1'b1, `DCD_ADDR_CTRL, 8'h00);
      cyc(2);
      chk(8'h01, {7'h0, oen0});
      acc(1'b1, `DCD_ADDR_CTRL, 8'h80);
      cyc(110);
      chk(w, out1);
      chk(8'h00, {7'h0, oen1});
      chk(8'h00, out0);
      tally_and_finish;
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      fails++;
      tally_and_finish;
   end
endmodule // dcd_dac_ctrl_tb
bind dcd_dac_ctrl dcd_chk chk_u (
   .sys_clk                     (sys_clk),
   .nrst                        (nrst),
   .bus_sel                     (bus_sel),
   .bus_wr                      (bus_wr),
   .bus_addr                    (bus_addr),
   .bus_wdata                   (bus_wdata),
   .standby                     (standby),
   .bus_rdata_ff                (bus_rdata_ff),
   .analog_out_channel0_ff      (analog_out_channel0_ff),
   .analog_out_channel1_ff      (analog_out_channel1_ff),
   .analog_out_channel0_oe_n_ff (analog_out_channel0_oe_n_ff),
   .analog_out_channel1_oe_n_ff (analog_out_channel1_oe_n_ff),
   .conv_active0_ff             (conv_active0_ff),
   .conv_active1_ff             (conv_active1_ff)
);
`default_nettype wire
